// File: verilog/file_reg_exec.sv
// Executor for complement, exclusive-OR and compare-skip register ops
//
// Contract
// - Complement writes inverted register, sets N and Z.
// - Destination bit 0 to work, 1 to register.
// - Access bit 0 uses access bank, 1 bank select.
// - Compare-skip subtracts unsigned, writes nothing, no flags.
// - On equal, fetched next instruction becomes no-operation.
// - Compare-skip one word, one, two or three cycles.
// - Exclusive-OR work with register, sets N and Z.
// - Instruction cycle lasts four oscillator periods.
`timescale 1ns/100ps

module file_reg_exec (
	input  wire logic                                   clk,
	input  wire logic                                   reset,
	input  wire logic [file_reg_exec_pkg::INSTR_W-1:0]  instr_word,
	input  wire logic [file_reg_exec_pkg::BANK_W-1:0]   bank_select_register,
	input  wire logic [file_reg_exec_pkg::DATA_W-1:0]   file_rd_data,
	output file_reg_exec_pkg::file_read_t               file_rd,
	output file_reg_exec_pkg::file_write_t              file_wr,
	output logic [file_reg_exec_pkg::DATA_W-1:0]        work_reg,
	output file_reg_exec_pkg::flags_t                   flags,
	output file_reg_exec_pkg::phase_t                   phase,
	output logic                                        cycle_start,
	output logic                                        discarding
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		file_reg_exec_pkg::phase_t      phase;
		file_reg_exec_pkg::op_kind_t    op;
		logic                           to_file;
		logic [file_reg_exec_pkg::BANK_W+file_reg_exec_pkg::FILE_ADDR_W-1:0]
		                                addr;
		logic                           skip_next;
		logic                           skip_second;
		logic                           discarding;
		logic                           cycle_start;
		file_reg_exec_pkg::file_read_t  rd;
		file_reg_exec_pkg::file_write_t wr;
		logic [file_reg_exec_pkg::DATA_W-1:0] work;
		file_reg_exec_pkg::flags_t      flags;
	} state_t;

	state_t state_q;
	state_t state_d;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	// Effective address from access bit, bank select and offset
	function automatic logic [11:0] eff_addr(
		input logic [15:0] word,
		input logic [3:0]  bank
	);
		logic [7:0] f;
		f = word[file_reg_exec_pkg::FILE_ADDR_W-1:0];
		if (!word[file_reg_exec_pkg::ACCESS_BIT]) begin
			eff_addr = (f < file_reg_exec_pkg::ACCESS_SPLIT) ?
				{file_reg_exec_pkg::ACCESS_LOW, f} :
				{file_reg_exec_pkg::ACCESS_HIGH, f};
		end else begin
			eff_addr = {bank, f};
		end
	endfunction

	// Opcode class of a fetched word
	function automatic file_reg_exec_pkg::op_kind_t op_of(
		input logic [15:0] word
	);
		if (word[15:file_reg_exec_pkg::OP6_LSB] ==
		    file_reg_exec_pkg::OP_COMPLEMENT) begin
			op_of = file_reg_exec_pkg::OPK_COMPL;
		end else if (word[15:file_reg_exec_pkg::OP6_LSB] ==
		             file_reg_exec_pkg::OP_XOR_WORK) begin
			op_of = file_reg_exec_pkg::OPK_XOR;
		end else if (word[15:file_reg_exec_pkg::OP7_LSB] ==
		             file_reg_exec_pkg::OP_CMP_SKIP) begin
			op_of = file_reg_exec_pkg::OPK_CMP;
		end else begin
			op_of = file_reg_exec_pkg::OPK_NONE;
		end
	endfunction

	// True for the first word of a two-word instruction
	function automatic logic two_word(input logic [15:0] word);
		two_word = (word[15:12] == file_reg_exec_pkg::OP_MOVE_FF) ||
		           (word[15:9]  == file_reg_exec_pkg::OP_CALL) ||
		           (word[15:8]  == file_reg_exec_pkg::OP_LOAD_FSR) ||
		           (word[15:8]  == file_reg_exec_pkg::OP_GOTO);
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Phase rotation gives one instruction per four clocks
	always_comb begin
		logic [7:0] result;
		result          = '0;
		state_d         = state_q;
		state_d.rd.en   = 1'b0;
		state_d.wr.en   = 1'b0;
		state_d.cycle_start = 1'b0;
		unique case (state_q.phase)
			file_reg_exec_pkg::PH_DECODE: begin
				state_d.phase = file_reg_exec_pkg::PH_READ;
				if (state_q.skip_second) begin
					// Second word of a skipped two-word op
					state_d.op          = file_reg_exec_pkg::OPK_NONE;
					state_d.skip_second = 1'b0;
					state_d.discarding  = 1'b1;
				end else if (state_q.skip_next) begin
					state_d.op          = file_reg_exec_pkg::OPK_NONE;
					state_d.skip_next   = 1'b0;
					state_d.skip_second = two_word(instr_word);
					state_d.discarding  = 1'b1;
				end else begin
					state_d.op         = op_of(instr_word);
					state_d.to_file    =
						instr_word[file_reg_exec_pkg::DEST_BIT];
					state_d.addr       =
						eff_addr(instr_word, bank_select_register);
					state_d.discarding = 1'b0;
					// Read strobe stands through the read phase
					state_d.rd.en   = (op_of(instr_word) !=
					                   file_reg_exec_pkg::OPK_NONE);
					state_d.rd.addr = eff_addr(instr_word,
					                           bank_select_register);
				end
			end
			file_reg_exec_pkg::PH_READ: begin
				state_d.phase = file_reg_exec_pkg::PH_PROCESS;
			end
			file_reg_exec_pkg::PH_PROCESS: begin
				// Memory answers one clock after the strobe
				state_d.phase = file_reg_exec_pkg::PH_WRITE;
				unique case (state_q.op)
					file_reg_exec_pkg::OPK_COMPL: begin
						result = ~file_rd_data;
					end
					file_reg_exec_pkg::OPK_XOR: begin
						result = state_q.work ^ file_rd_data;
					end
					file_reg_exec_pkg::OPK_CMP: begin
						// Zero difference means equal; nothing stored
						result = file_rd_data - state_q.work;
						state_d.skip_next = (result == 8'h00);
					end
					file_reg_exec_pkg::OPK_NONE: begin
						result = '0;
					end
				endcase
				if (state_q.op == file_reg_exec_pkg::OPK_COMPL ||
				    state_q.op == file_reg_exec_pkg::OPK_XOR) begin
					state_d.flags.neg  = result[7];
					state_d.flags.zero = (result == 8'h00);
					if (state_q.to_file) begin
						state_d.wr.en   = 1'b1;
						state_d.wr.addr = state_q.addr;
						state_d.wr.data = result;
					end else begin
						state_d.work = result;
					end
				end
			end
			file_reg_exec_pkg::PH_WRITE: begin
				state_d.phase       = file_reg_exec_pkg::PH_DECODE;
				state_d.cycle_start = 1'b1;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Reset lands in the decode phase with no skip pending
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q             <= '0;
			state_q.phase       <= file_reg_exec_pkg::PH_DECODE;
			state_q.op          <= file_reg_exec_pkg::OPK_NONE;
			state_q.to_file     <= 1'b1;
			state_q.cycle_start <= 1'b1;
			state_q.work        <= file_reg_exec_pkg::WORK_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from the state flops
	// ----------------------------------------------------------------
	assign file_rd     = state_q.rd;
	assign file_wr     = state_q.wr;
	assign work_reg    = state_q.work;
	assign flags       = state_q.flags;
	assign phase       = state_q.phase;
	assign cycle_start = state_q.cycle_start;
	assign discarding  = state_q.discarding;

endmodule

// File: verilog/file_reg_exec_pkg.sv
// Package: encodings, field layout and timing of the file-register executor
package file_reg_exec_pkg;

	// ----------------------------------------------------------------
	// Instruction word layout
	// ----------------------------------------------------------------
	localparam int INSTR_W      = 16;
	localparam int FILE_ADDR_W  = 8;
	localparam int BANK_W       = 4;
	localparam int DATA_W       = 8;
	localparam int DEST_BIT     = 9;
	localparam int ACCESS_BIT   = 8;
	localparam int OP6_LSB      = 10;
	localparam int OP7_LSB      = 9;

	// Opcode patterns in the upper bits of the word
	localparam logic [5:0] OP_COMPLEMENT = 6'h07; // 0001 11da
	localparam logic [5:0] OP_XOR_WORK   = 6'h06; // 0001 10da
	localparam logic [6:0] OP_CMP_SKIP   = 7'h31; // 0110 001a

	// Two-word instructions, second word must be dropped on a skip
	localparam logic [3:0] OP_MOVE_FF    = 4'hC;
	localparam logic [6:0] OP_CALL       = 7'h76;
	localparam logic [7:0] OP_LOAD_FSR   = 8'hEE;
	localparam logic [7:0] OP_GOTO       = 8'hEF;

	// Access bank split: low half in bank 0, high half in the top bank
	localparam logic [7:0] ACCESS_SPLIT  = 8'h80;
	localparam logic [3:0] ACCESS_LOW    = 4'h0;
	localparam logic [3:0] ACCESS_HIGH   = 4'hF;

	// Reset values
	localparam logic [7:0] WORK_RESET    = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int OSC_PERIOD_NS      = 20;
	localparam int PHASES_PER_CYCLE   = 4;
	localparam int INSTR_CYCLE_NS     = PHASES_PER_CYCLE * OSC_PERIOD_NS;
	localparam int CLKS_PER_INSTR     = INSTR_CYCLE_NS / OSC_PERIOD_NS;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		PH_DECODE  = 4'h1,
		PH_READ    = 4'h2,
		PH_PROCESS = 4'h4,
		PH_WRITE   = 4'h8
	} phase_t;

	typedef enum logic [3:0] {
		OPK_NONE   = 4'h1,
		OPK_COMPL  = 4'h2,
		OPK_XOR    = 4'h4,
		OPK_CMP    = 4'h8
	} op_kind_t;

	typedef struct packed {
		logic                         en;
		logic [BANK_W+FILE_ADDR_W-1:0] addr;
	} file_read_t;

	typedef struct packed {
		logic                         en;
		logic [BANK_W+FILE_ADDR_W-1:0] addr;
		logic [DATA_W-1:0]            data;
	} file_write_t;

	typedef struct packed {
		logic neg;
		logic zero;
	} flags_t;

endpackage

// File: test/file_reg_exec_props.sv
// Checker: cycle timing and results of the file-register executor
`timescale 1ns/100ps
module file_reg_exec_props (
	input logic                           clk,
	input logic                           reset,
	input logic [15:0]                    instr_word,
	input logic [3:0]                     bank_select_register,
	input logic [7:0]                     file_rd_data,
	input file_reg_exec_pkg::file_read_t  file_rd,
	input file_reg_exec_pkg::file_write_t file_wr,
	input logic [7:0]                     work_reg,
	input file_reg_exec_pkg::flags_t      flags,
	input file_reg_exec_pkg::phase_t      phase,
	input logic                           cycle_start,
	input logic                           discarding
);
	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	wire       dec = phase == file_reg_exec_pkg::PH_DECODE;
	wire [6:0] op  = instr_word[15:9];
	wire       cmp = dec && op == file_reg_exec_pkg::OP_CMP_SKIP;
	wire       cpl = dec && op[6:1] == file_reg_exec_pkg::OP_COMPLEMENT;
	wire       xr  = dec && op[6:1] == file_reg_exec_pkg::OP_XOR_WORK;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Access bit 0 picks bank 0 or the top bank by address half
	function automatic logic [11:0] ea(logic [15:0] w, logic [3:0] b);
		return {w[8] ? b : {4{w[7]}}, w[7:0]};
	endfunction

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_cycle;
		dec |=> !dec[*3] ##1 (dec && cycle_start);
	endproperty
	a_cycle: assert property (p_cycle) else $error("bad cycle");
	property p_wr;
		file_wr.en |-> $past(dec, 3);
	endproperty
	a_wr: assert property (p_wr) else $error("write off phase");
	property p_cpl;
		cpl && op[0] |=> ##2
			discarding || file_wr.en && file_wr.data == ~$past(file_rd_data);
	endproperty
	a_cpl: assert property (p_cpl) else $error("bad complement");
	property p_xor;
		xr && !op[0] |=> ##2 discarding || !file_wr.en
			&& work_reg == ($past(work_reg) ^ $past(file_rd_data))
			&& flags == {work_reg[7], work_reg == 8'h00};
	endproperty
	a_xor: assert property (p_xor) else $error("bad xor");
	property p_addr;
		cpl || xr || cmp |=> discarding || file_rd.en && file_rd.addr
			== ea($past(instr_word), $past(bank_select_register));
	endproperty
	a_addr: assert property (p_addr) else $error("bad address");
	property p_cmp;
		cmp |=> ##2 !file_wr.en && $stable(flags) && $stable(work_reg);
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare wrote");
	property p_skip;
		cmp ##2 (file_rd_data == work_reg && !discarding)
			|=> ##2 discarding[*3];
	endproperty
	a_skip: assert property (p_skip) else $error("no skip");
	property p_noskip;
		cmp ##2 (file_rd_data != work_reg && !discarding)
			|=> ##2 !discarding[*3];
	endproperty
	a_noskip: assert property (p_noskip) else $error("false skip");
endmodule

bind file_reg_exec file_reg_exec_props i_file_reg_exec_props (
	.clk(clk), .reset(reset), .instr_word(instr_word),
	.bank_select_register(bank_select_register),
	.file_rd_data(file_rd_data), .file_rd(file_rd), .file_wr(file_wr),
	.work_reg(work_reg), .flags(flags), .phase(phase),
	.cycle_start(cycle_start), .discarding(discarding));

// File: test/test_file_reg_exec.sv
// Testbench: directed scenarios for the file-register executor
`timescale 1ns/100ps
module test_file_reg_exec;
	logic                           clk = 1'b0;
	logic                           reset = 1'b1;
	logic [15:0]                    instr_word = 16'h0000;
	logic [3:0]                     bank_select_register = 4'h0;
	logic [7:0]                     file_rd_data = 8'h00;
	file_reg_exec_pkg::file_read_t  file_rd;
	file_reg_exec_pkg::file_write_t file_wr;
	logic [7:0]                     work_reg;
	file_reg_exec_pkg::flags_t      flags;
	file_reg_exec_pkg::phase_t      phase;
	logic                           cycle_start;
	logic                           discarding;
	int                             fails = 0;
	int                             n_compared = 0;
	int                             ticks = 0;
	logic [11:0]                    ra;
	logic [7:0]                     wd;
	logic                           we;
	logic                           re;
	logic [11:0]                    wa;
	logic                           dc;

	file_reg_exec i_file_reg_exec (
		.clk(clk), .reset(reset), .instr_word(instr_word),
		.bank_select_register(bank_select_register),
		.file_rd_data(file_rd_data), .file_rd(file_rd), .file_wr(file_wr),
		.work_reg(work_reg), .flags(flags), .phase(phase),
		.cycle_start(cycle_start), .discarding(discarding));

	// ----------------------------------------
	// Clock, timeout, shared tasks
	// ----------------------------------------
	always #10 clk = ~clk;
	// A hung run counts as a mismatch
	always @(posedge clk) begin
		ticks++;
		if (ticks == 1000) begin
			fails++;
			give_verdict();
		end
	end
	task check(input logic [11:0] seen, input logic [11:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task give_verdict;
		if (fails == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// One instruction cycle; entered at the falling edge inside decode
	task issue(input logic [15:0] w, input logic [3:0] b,
		input logic [7:0] d);
		instr_word = w;
		bank_select_register = b;
		file_rd_data = d;
		@(negedge clk);
		ra = file_rd.addr;
		re = file_rd.en;
		dc = discarding;
		repeat (2) @(negedge clk);
		we = file_wr.en;
		wd = file_wr.data;
		wa = file_wr.addr;
		@(negedge clk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_complement;
		issue(16'h1F45, 4'h3, 8'h13);
		check(ra, 12'h345);
		check({1'b0, we, wd, flags}, {2'b01, 8'hEC, 2'h2});
		check(wa, 12'h345);
		check({11'h000, re}, 12'h001);
		check({cycle_start, phase}, 12'h011);
		issue(16'h1C90, 4'h3, 8'hFF);
		check(ra, 12'hF90);
		check({dc, we, work_reg, flags}, {2'b00, 8'h00, 2'h1});
	endtask
	task t_xor;
		issue(16'h1810, 4'h0, 8'hB5);
		check(ra, 12'h010);
		check({dc, we, work_reg, flags}, {2'b00, 8'hB5, 2'h2});
		issue(16'h1BAF, 4'h2, 8'hAF);
		check(ra, 12'h2AF);
		check({1'b0, we, wd, flags}, {2'b01, 8'h1A, 2'h0});
		check(work_reg, 12'h0B5);
	endtask
	// Unequal, equal, then equal ahead of a two-word instruction
	task t_compare;
		issue(16'h6320, 4'h1, 8'h11);
		check({dc, we, work_reg, flags}, {2'b00, 8'hB5, 2'h0});
		issue(16'h1D00, 4'h1, 8'h4A);
		check({dc, we, work_reg, flags}, {2'b00, 8'hB5, 2'h2});
		issue(16'h6234, 4'h1, 8'hB5);
		check(ra, 12'h034);
		issue(16'h1F00, 4'h0, 8'h00);
		check({dc, we, work_reg, flags}, {2'b10, 8'hB5, 2'h2});
		issue(16'h1C00, 4'h0, 8'h0F);
		check({dc, we, work_reg, flags}, {2'b00, 8'hF0, 2'h2});
		issue(16'h63AA, 4'h0, 8'hF0);
		issue(16'hEF01, 4'h0, 8'h00);
		check({dc, we}, 12'h002);
		issue(16'h1C00, 4'h0, 8'h00);
		check({dc, we, work_reg, flags}, {2'b10, 8'hF0, 2'h2});
		issue(16'h1C00, 4'h0, 8'hF0);
		check({dc, we, work_reg, flags}, {2'b00, 8'h0F, 2'h0});
		issue(16'h0000, 4'h0, 8'h55);
		check({re, we, work_reg, flags}, {2'b00, 8'h0F, 2'h0});
	endtask

	initial begin
		repeat (16) @(negedge clk);
		reset = 1'b0;
		t_complement();
		t_xor();
		t_compare();
		give_verdict();
	end
endmodule
